// [rtl/dpo_defs.svh]
`ifndef DPO_DEFS_SVH
`define DPO_DEFS_SVH
// Register byte addresses.
`define DPO_A_BUILD_OUT_CTRL 8'h00
`define DPO_A_FRAME_SYNC_CTRL3 8'h01
`define DPO_A_MAIN_PLL_CTRL1 8'h02
`define DPO_A_MASTER_CTRL4 8'h03
`define DPO_A_MASTER_CTRL11 8'h04
`define DPO_A_OFFSET_LO 8'h05
`define DPO_A_OFFSET_MID 8'h06
`define DPO_A_OFFSET_HI 8'h07
`define DPO_A_READOUT_FIELD_A_A 8'h08
`define DPO_A_READOUT_FIELD_A_B 8'h09
`define DPO_A_READOUT_FIELD_A_C 8'h0A
`define DPO_A_PHASE_A 8'h0B
`define DPO_A_PHASE_B 8'h0C
`define DPO_A_INPUT_CFG 8'h0D
`define DPO_A_BANDWIDTH 8'h0E
`define DPO_A_STATUS 8'h0F
`define DPO_A_READOUT_FIELD_A_LIMIT 8'h10
`define DPO_A_SLEW_LIMIT 8'h11
`define DPO_A_COPY_DIV_LO 8'h12
`define DPO_A_COPY_DIV_HI 8'h13
// Field positions.
`define DPO_B_BUILD_OUT_EN 0
`define DPO_B_RECALIBRATION_TRIGGER_TRIG 0
`define DPO_B_RECALIBRATION_TRIGGER_BUSY 1
`define DPO_B_AUX_MEAS_MAIN 0
`define DPO_F_FORCE_SEL 2:0
`define DPO_B_MEAS_SRC 0
`define DPO_F_MAIN_MODE 1:0
`define DPO_F_AUX_MODE 3:2
`define DPO_F_MAIN_BW 4:0
`define DPO_F_AUX_BW 6:5
// Locking modes of a reference.
`define DPO_MODE_DIRECT 2'h0
`define DPO_MODE_EIGHT_KHZ_LOCK_MODE 2'h1
`define DPO_MODE_DIVN8K 2'h2
`define DPO_MODE_DIVIDE_BY_N_MODE_OTHER 2'h3
// Main loop state codes.
`define DPO_ST_FREERUN 2'h0
`define DPO_ST_HOLDOVER 2'h1
`define DPO_ST_LOCKING 2'h2
`define DPO_ST_LOCKED 2'h3
// Limits and reset values.
`define DPO_MAIN_BW_MAX 5'h14
`define DPO_OFFSET_STEP_FS 6000
`define DPO_OFFSET_RANGE_PS 200000
`define DPO_RST_LIMIT 8'h15
`define DPO_RST_COPY_DIV 16'h0001
`endif

// [rtl/dpo_pkg.sv]
package dpo_pkg;
  typedef enum logic [2:0] {
    DPO_IDLE,
    DPO_ENTER,
    DPO_ZERO,
    DPO_DIVRST,
    DPO_RESTORE,
    DPO_LEAVE
  } dpo_recalibration_trigger_t;
  typedef logic [1:0] dpo_mode_t;
endpackage : dpo_pkg

// [rtl/dpo_top.sv]
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "dpo_defs.svh"
module dpo_top import dpo_pkg::*; #(
  parameter int NUM_IN = 8,
  parameter int OFS_W = 17,
  parameter int READOUT_FIELD_A_W = 24,
  parameter int PHASE_W = 16,
  parameter int RAMP_STEP = 4,
  parameter int DIV_RST_CYC = 8,
  parameter int LPF_SHIFT = 10
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [NUM_IN-1:0] ref_clk_i,
  input wire logic [2:0] main_sel_i,
  input wire logic [2:0] aux_auto_sel_i,
  input wire logic [1:0] main_state_i,
  input wire logic [READOUT_FIELD_A_W-1:0] main_integral_i,
  input wire logic [READOUT_FIELD_A_W-1:0] aux_integral_i,
  input wire logic [PHASE_W-1:0] main_pd_err_i,
  input wire logic [PHASE_W-1:0] aux_pd_err_i,
  input wire logic pd_sample_i,
  input wire logic [NUM_IN*8-1:0] in_readout_field_a_i,
  input wire logic in_meas_stb_i,
  output logic [OFS_W-1:0] fb_offset_o,
  output logic mini_holdover_o,
  output logic div_reset_o,
  output logic zero_phase_lock_o,
  output logic aux_freerun_o,
  output logic aux_cmp_main_o,
  output logic [2:0] aux_ref_sel_o,
  output logic [1:0] copy_mode_o,
  output logic copy_ref_o,
  output logic [4:0] main_bw_o,
  output logic [1:0] aux_bw_o,
  output logic [NUM_IN-1:0] in_valid_o
);

  localparam logic [OFS_W-1:0] STEP = OFS_W'(RAMP_STEP);
  localparam logic [7:0] DIV_LAST = 8'(DIV_RST_CYC - 1);

  logic build_out_enable;
  logic aux_measures_main_mode;
  logic [3:0] master_control_reg4;
  logic measurement_source_select;
  logic [OFS_W-1:0] offset_reg;
  logic [3:0] input_config_reg;
  logic [6:0] bw_reg;
  logic [7:0] input_readout_field_a_limit;
  logic [7:0] slew_rate_limit;
  logic [15:0] copy_half_div;
  logic recalibration_trigger_start;
  dpo_recalibration_trigger_t recalibration_trigger_state;
  logic [7:0] div_cnt;
  logic [OFS_W-1:0] applied;
  logic [READOUT_FIELD_A_W-1:0] readout_field_a_live;
  logic [READOUT_FIELD_A_W-1:0] readout_field_a_snap;
  logic [PHASE_W-1:0] phase_filt;
  logic [PHASE_W-1:0] phase_snap;
  logic [NUM_IN-1:0] sync1, sync2, sync3, ref_level;
  logic copy_prev;
  logic [15:0] copy_cnt;

  wire wr_hit = wr_i;
  wire locking = (main_state_i == `DPO_ST_LOCKING) || (main_state_i == `DPO_ST_LOCKED);
  wire recalibration_trigger_busy = (recalibration_trigger_state != DPO_IDLE);

  // Software-written configuration; the trigger bit is a one-cycle start, not stored.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      build_out_enable <= 1'b0;
      aux_measures_main_mode <= 1'b0;
      master_control_reg4 <= 4'h0;
      measurement_source_select <= 1'b0;
      offset_reg <= '0;
      input_config_reg <= 4'h0;
      bw_reg <= 7'h00;
      input_readout_field_a_limit <= `DPO_RST_LIMIT;
      slew_rate_limit <= `DPO_RST_LIMIT;
      copy_half_div <= `DPO_RST_COPY_DIV;
      recalibration_trigger_start <= 1'b0;
    end else begin
      recalibration_trigger_start <= wr_hit && (addr_i == `DPO_A_FRAME_SYNC_CTRL3) && wdata_i[`DPO_B_RECALIBRATION_TRIGGER_TRIG];
      if (wr_hit) begin
        unique case (addr_i)
          `DPO_A_BUILD_OUT_CTRL: build_out_enable <= wdata_i[`DPO_B_BUILD_OUT_EN];
          `DPO_A_MAIN_PLL_CTRL1: aux_measures_main_mode <= wdata_i[`DPO_B_AUX_MEAS_MAIN];
          `DPO_A_MASTER_CTRL4: master_control_reg4 <= wdata_i[3:0];
          `DPO_A_MASTER_CTRL11: measurement_source_select <= wdata_i[`DPO_B_MEAS_SRC];
          `DPO_A_OFFSET_LO: offset_reg[7:0] <= wdata_i;
          `DPO_A_OFFSET_MID: offset_reg[15:8] <= wdata_i;
          `DPO_A_OFFSET_HI: offset_reg[OFS_W-1:16] <= wdata_i[OFS_W-17:0];
          `DPO_A_INPUT_CFG: input_config_reg <= wdata_i[3:0];
          `DPO_A_BANDWIDTH: begin
            // Out-of-range main corners clamp to the highest of the 21 settings.
            bw_reg[`DPO_F_MAIN_BW] <= (wdata_i[4:0] > `DPO_MAIN_BW_MAX) ? `DPO_MAIN_BW_MAX : wdata_i[4:0];
            bw_reg[`DPO_F_AUX_BW] <= wdata_i[6:5];
          end
          `DPO_A_READOUT_FIELD_A_LIMIT: input_readout_field_a_limit <= wdata_i;
          `DPO_A_SLEW_LIMIT: slew_rate_limit <= wdata_i;
          `DPO_A_COPY_DIV_LO: copy_half_div[7:0] <= wdata_i;
          `DPO_A_COPY_DIV_HI: copy_half_div[15:8] <= wdata_i;
          default: ;
        endcase
      end
    end
  end

  // Recalibration sequencer; the restore leg always chases the live offset register.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      recalibration_trigger_state <= DPO_IDLE;
      div_cnt <= 8'h00;
    end else begin
      unique case (recalibration_trigger_state)
        DPO_IDLE: if (recalibration_trigger_start) recalibration_trigger_state <= DPO_ENTER;
        DPO_ENTER: recalibration_trigger_state <= DPO_ZERO;
        DPO_ZERO: begin
          div_cnt <= 8'h00;
          if (applied == '0) recalibration_trigger_state <= DPO_DIVRST;
        end
        DPO_DIVRST: begin
          div_cnt <= div_cnt + 8'h01;
          if (div_cnt == DIV_LAST) recalibration_trigger_state <= DPO_RESTORE;
        end
        DPO_RESTORE: if (applied == offset_reg) recalibration_trigger_state <= DPO_LEAVE;
        DPO_LEAVE: recalibration_trigger_state <= DPO_IDLE;
      endcase
    end
  end

  // Hold and divider reset strobes for the loop and the output dividers.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mini_holdover_o <= 1'b0;
      div_reset_o <= 1'b0;
    end else begin
      mini_holdover_o <= (recalibration_trigger_state == DPO_ENTER) || (recalibration_trigger_state == DPO_ZERO) ||
                         (recalibration_trigger_state == DPO_DIVRST) || (recalibration_trigger_state == DPO_RESTORE);
      div_reset_o <= (recalibration_trigger_state == DPO_DIVRST);
    end
  end

  // Feedback offset ramp. Moving a bounded step per cycle lets the loop absorb the
  // change at its own bandwidth instead of seeing a phase hit.
  logic [OFS_W-1:0] ramp_target;
  logic ramp_allowed;
  logic [OFS_W:0] diff;
  logic [OFS_W-1:0] next_applied;
  // The offset stays parked at zero until the divider reset is over, so the dividers realign at zero phase.
  // One spare bit keeps the difference of two full-range offsets from wrapping its sign.
  always_comb begin
    ramp_target = (recalibration_trigger_state == DPO_ZERO || recalibration_trigger_state == DPO_ENTER || recalibration_trigger_state == DPO_DIVRST) ?
                  '0 : offset_reg;
    ramp_allowed = recalibration_trigger_busy || (!build_out_enable && locking);
    diff = {ramp_target[OFS_W-1], ramp_target} - {applied[OFS_W-1], applied};
    next_applied = applied;
    if (ramp_allowed && diff != '0) begin
      if (!diff[OFS_W]) next_applied = (diff > {1'b0, STEP}) ? applied + STEP : ramp_target;
      else next_applied = ((-diff) > {1'b0, STEP}) ? applied - STEP : ramp_target;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      applied <= '0;
      fb_offset_o <= '0;
    end else begin
      applied <= next_applied;
      fb_offset_o <= next_applied;
    end
  end

  // Measurement-mode steering of the auxiliary loop; the main loop is left untouched.
  function automatic dpo_mode_t copy_mode(input dpo_mode_t aux_m, input dpo_mode_t main_m);
    dpo_mode_t m;
    m = `DPO_MODE_DIRECT;
    if (aux_m == `DPO_MODE_EIGHT_KHZ_LOCK_MODE || aux_m == `DPO_MODE_DIVN8K) begin
      if (main_m == `DPO_MODE_DIRECT || main_m == `DPO_MODE_EIGHT_KHZ_LOCK_MODE) m = `DPO_MODE_EIGHT_KHZ_LOCK_MODE;
      else if (main_m == `DPO_MODE_DIVN8K) m = `DPO_MODE_DIVN8K;
    end
    return m;
  endfunction : copy_mode

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aux_freerun_o <= 1'b0;
      aux_cmp_main_o <= 1'b0;
      aux_ref_sel_o <= 3'h0;
      copy_mode_o <= `DPO_MODE_DIRECT;
      zero_phase_lock_o <= 1'b1;
      main_bw_o <= 5'h00;
      aux_bw_o <= 2'h0;
    end else begin
      aux_freerun_o <= aux_measures_main_mode;
      aux_cmp_main_o <= aux_measures_main_mode;
      aux_ref_sel_o <= aux_measures_main_mode ? master_control_reg4[`DPO_F_FORCE_SEL] : aux_auto_sel_i;
      copy_mode_o <= copy_mode(input_config_reg[`DPO_F_AUX_MODE], input_config_reg[`DPO_F_MAIN_MODE]);
      zero_phase_lock_o <= !build_out_enable;
      main_bw_o <= bw_reg[`DPO_F_MAIN_BW];
      aux_bw_o <= bw_reg[`DPO_F_AUX_BW];
    end
  end

  // Reference pins: three flops, and a level only moves once the last two agree.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_ref
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          ref_level[gi] <= 1'b0;
        end else begin
          sync1[gi] <= ref_clk_i[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) ref_level[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // Copy of the main reference; divided when the aux path locks at 8 kHz, unless the main mode is the other divide-by-N mode.
  wire copy_src = ref_level[main_sel_i];
  wire copy_div = (copy_mode_o != `DPO_MODE_DIRECT);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      copy_prev <= 1'b0;
      copy_cnt <= 16'h0000;
      copy_ref_o <= 1'b0;
    end else begin
      copy_prev <= copy_src;
      if (!copy_div) begin
        copy_cnt <= 16'h0000;
        copy_ref_o <= copy_src;
      end else if (copy_src && !copy_prev) begin
        if (copy_cnt + 16'h0001 >= copy_half_div) begin
          copy_cnt <= 16'h0000;
          copy_ref_o <= !copy_ref_o;
        end else begin
          copy_cnt <= copy_cnt + 16'h0001;
        end
      end
    end
  end

  // Readout sources; frequency is the raw integral value, phase gets a one-pole filter.
  // The filter shift sets the corner against the detector sample rate.
  logic [PHASE_W-1:0] pd_sel;
  logic [PHASE_W+LPF_SHIFT-1:0] phase_acc;
  logic [PHASE_W+LPF_SHIFT-1:0] acc_step;
  always_comb begin
    pd_sel = measurement_source_select ? aux_pd_err_i : main_pd_err_i;
    acc_step = {{LPF_SHIFT{pd_sel[PHASE_W-1]}}, pd_sel} -
               {{LPF_SHIFT{phase_acc[PHASE_W+LPF_SHIFT-1]}}, phase_acc[PHASE_W+LPF_SHIFT-1:LPF_SHIFT]};
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_acc <= '0;
      phase_filt <= '0;
      readout_field_a_live <= '0;
    end else begin
      if (pd_sample_i) phase_acc <= phase_acc + acc_step;
      phase_filt <= phase_acc[PHASE_W+LPF_SHIFT-1:LPF_SHIFT];
      readout_field_a_live <= measurement_source_select ? aux_integral_i : main_integral_i;
    end
  end

  // Input validity from the per-input monitors, in 3.8 ppm units.
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_mon
      logic [7:0] last;
      logic [7:0] cur;
      logic [7:0] slew;
      always_comb begin
        cur = in_readout_field_a_i[gi*8 +: 8];
        slew = cur - last;
      end
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          last <= 8'h00;
          in_valid_o[gi] <= 1'b0;
        end else if (in_meas_stb_i) begin
          last <= cur;
          in_valid_o[gi] <= ((cur[7] ? -cur : cur) <= input_readout_field_a_limit) &&
                            ((slew[7] ? -slew : slew) <= slew_rate_limit);
        end
      end
    end
  endgenerate

  // Read port. Reading the low byte freezes the rest so a multi-byte walk is coherent.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
      readout_field_a_snap <= '0;
      phase_snap <= '0;
    end else begin
      rdata_o <= 8'h00;
      if (rd_i) begin
        unique case (addr_i)
          `DPO_A_BUILD_OUT_CTRL: rdata_o <= {7'h00, build_out_enable};
          `DPO_A_FRAME_SYNC_CTRL3: rdata_o <= {6'h00, recalibration_trigger_busy, 1'b0};
          `DPO_A_MAIN_PLL_CTRL1: rdata_o <= {7'h00, aux_measures_main_mode};
          `DPO_A_MASTER_CTRL4: rdata_o <= {4'h0, master_control_reg4};
          `DPO_A_MASTER_CTRL11: rdata_o <= {7'h00, measurement_source_select};
          `DPO_A_OFFSET_LO: rdata_o <= offset_reg[7:0];
          `DPO_A_OFFSET_MID: rdata_o <= offset_reg[15:8];
          `DPO_A_OFFSET_HI: rdata_o <= 8'(offset_reg[OFS_W-1:16]);
          `DPO_A_READOUT_FIELD_A_A: begin
            rdata_o <= readout_field_a_live[7:0];
            readout_field_a_snap <= readout_field_a_live;
          end
          `DPO_A_READOUT_FIELD_A_B: rdata_o <= readout_field_a_snap[15:8];
          `DPO_A_READOUT_FIELD_A_C: rdata_o <= readout_field_a_snap[23:16];
          `DPO_A_PHASE_A: begin
            rdata_o <= phase_filt[7:0];
            phase_snap <= phase_filt;
          end
          `DPO_A_PHASE_B: rdata_o <= phase_snap[15:8];
          `DPO_A_INPUT_CFG: rdata_o <= {4'h0, input_config_reg};
          `DPO_A_BANDWIDTH: rdata_o <= {1'b0, bw_reg};
          `DPO_A_STATUS: rdata_o <= {3'h0, ref_level[0], recalibration_trigger_busy, mini_holdover_o, main_state_i};
          `DPO_A_READOUT_FIELD_A_LIMIT: rdata_o <= input_readout_field_a_limit;
          `DPO_A_SLEW_LIMIT: rdata_o <= slew_rate_limit;
          `DPO_A_COPY_DIV_LO: rdata_o <= copy_half_div[7:0];
          `DPO_A_COPY_DIV_HI: rdata_o <= copy_half_div[15:8];
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Checks on the sequencer, ramp and measurement steering.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_recalibration_trigger_trigger_start: assert property (
    recalibration_trigger_start && recalibration_trigger_state == DPO_IDLE |=> recalibration_trigger_state == DPO_ENTER ##1 mini_holdover_o)
    else $error("recalibration did not start");
  a_recalibration_trigger_zero_first: assert property (
    recalibration_trigger_state == DPO_DIVRST |-> applied == '0)
    else $error("dividers reset before offset reached zero");
  a_div_reset_len: assert property (
    $rose(recalibration_trigger_state == DPO_DIVRST) |=> (recalibration_trigger_state == DPO_DIVRST)[*7] ##1 recalibration_trigger_state == DPO_RESTORE)
    else $error("divider reset length wrong");
  a_recalibration_trigger_leave_value: assert property (
    recalibration_trigger_state == DPO_LEAVE |-> applied == offset_reg)
    else $error("recalibration left at wrong offset");
  a_offset_hold_freerun: assert property (
    !recalibration_trigger_busy && !locking |=> $stable(applied))
    else $error("offset moved while free-running or holding");
  a_offset_ramp_step: assert property (
    (applied - $past(applied) <= STEP) || ($past(applied) - applied <= STEP))
    else $error("offset jumped by more than one step");
  a_offset_converge: assert property (
    !build_out_enable && locking && !recalibration_trigger_busy && applied != offset_reg &&
    $stable(offset_reg) |=> applied != $past(applied))
    else $error("offset not tracking register");
  a_meas_force_sel: assert property (
    aux_measures_main_mode |=> aux_ref_sel_o == $past(master_control_reg4[`DPO_F_FORCE_SEL]))
    else $error("forced aux reference not applied");
  a_meas_freerun: assert property (
    aux_measures_main_mode |=> aux_freerun_o && aux_cmp_main_o)
    else $error("aux loop not free-running in measure mode");
  a_readout_field_a_coherent: assert property (
    rd_i && addr_i == `DPO_A_READOUT_FIELD_A_A |=> readout_field_a_snap[7:0] == rdata_o)
    else $error("frequency snapshot not coherent");

  c_recalibration_trigger_run: cover property (recalibration_trigger_state == DPO_LEAVE);
  c_recalibration_trigger_retarget: cover property (recalibration_trigger_state == DPO_RESTORE && wr_i && addr_i == `DPO_A_OFFSET_LO);
  c_meas_div: cover property (aux_measures_main_mode && copy_mode_o == `DPO_MODE_DIVN8K);
  c_input_invalid: cover property (in_meas_stb_i ##1 !in_valid_o[0]);

endmodule : dpo_top

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "dpo_defs.svh"
module tb_top;
  logic clock_i;
  logic arst_n_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic [7:0] ref_clk_i = 8'h00;
  logic [2:0] main_sel_i;
  logic [2:0] aux_auto_sel_i;
  logic [1:0] main_state_i;
  logic [23:0] main_integral_i;
  logic [23:0] aux_integral_i;
  logic [15:0] main_pd_err_i;
  logic [15:0] aux_pd_err_i;
  logic pd_sample_i = 1'b0;
  logic [63:0] in_readout_field_a_i;
  logic in_meas_stb_i;
  logic [16:0] fb_offset_o;
  logic mini_holdover_o;
  logic div_reset_o;
  logic zero_phase_lock_o;
  logic aux_freerun_o;
  logic aux_cmp_main_o;
  logic [2:0] aux_ref_sel_o;
  logic [1:0] copy_mode_o;
  logic copy_ref_o;
  logic [4:0] main_bw_o;
  logic [1:0] aux_bw_o;
  logic [7:0] in_valid_o;
  int err_count;
  int n_tests;

  // A short filter shift keeps the phase averaging settle time small in simulation.
  dpo_top #(.LPF_SHIFT(2)) dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref_clk_i(ref_clk_i), .main_sel_i(main_sel_i),
    .aux_auto_sel_i(aux_auto_sel_i), .main_state_i(main_state_i), .main_integral_i(main_integral_i),
    .aux_integral_i(aux_integral_i), .main_pd_err_i(main_pd_err_i), .aux_pd_err_i(aux_pd_err_i),
    .pd_sample_i(pd_sample_i), .in_readout_field_a_i(in_readout_field_a_i), .in_meas_stb_i(in_meas_stb_i), .fb_offset_o(fb_offset_o),
    .mini_holdover_o(mini_holdover_o), .div_reset_o(div_reset_o), .zero_phase_lock_o(zero_phase_lock_o),
    .aux_freerun_o(aux_freerun_o), .aux_cmp_main_o(aux_cmp_main_o), .aux_ref_sel_o(aux_ref_sel_o),
    .copy_mode_o(copy_mode_o), .copy_ref_o(copy_ref_o), .main_bw_o(main_bw_o), .aux_bw_o(aux_bw_o),
    .in_valid_o(in_valid_o));

  // The clock inverts every half period of 2 ns.
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Reference pins and detector samples keep moving so the sync and filter paths see traffic.
  always @(posedge clock_i) begin
    ref_clk_i <= ref_clk_i + 8'h01;
    pd_sample_i <= ~pd_sample_i;
  end

  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Waiting one extra nanosecond lets the edge's own updates land before anything is sampled.
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data are only valid in the cycle after the strobe, so they are taken there.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, {16'h0000, e}, {16'h0000, rdata_o});
  endtask : rchk

  task automatic set_ofs(input logic [16:0] v);
    wr(`DPO_A_OFFSET_HI, {7'h00, v[16]});
    wr(`DPO_A_OFFSET_MID, v[15:8]);
    wr(`DPO_A_OFFSET_LO, v[7:0]);
  endtask : set_ofs

  task automatic wait_ofs(input logic [16:0] v);
    for (int i = 0; i < 3000 && fb_offset_o !== v; i++) tick(1);
    chk("fb_offset", {7'h00, v}, {7'h00, fb_offset_o});
  endtask : wait_ofs

  // Ten thousand cycles is several times what the sequence needs; then the run is closed.
  initial begin
    #40000;
    err_count++;
    complete_run();
  end

  initial begin
    int n;
    int t;
    logic p;
    err_count = 0;
    n_tests = 0;
    arst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    main_sel_i = 3'h1;
    aux_auto_sel_i = 3'h2;
    main_state_i = `DPO_ST_LOCKED;
    main_integral_i = 24'h123456;
    aux_integral_i = 24'hABCDEF;
    main_pd_err_i = 16'h0100;
    aux_pd_err_i = 16'hFF00;
    in_readout_field_a_i = 64'h0000_0000_00EB_1E0A;
    in_meas_stb_i = 1'b0;
    tick(16);
    arst_n_i <= 1'b1;
    tick(2);
    // Reset values and an unmapped place.
    rchk(`DPO_A_READOUT_FIELD_A_LIMIT, 8'h15, "readout_field_a_limit");
    rchk(`DPO_A_SLEW_LIMIT, 8'h15, "slew_limit");
    rchk(`DPO_A_COPY_DIV_LO, 8'h01, "copy_div_lo");
    rchk(8'h3C, 8'h00, "unmapped");
    chk("zero_phase_lock", 24'h1, {23'h0, zero_phase_lock_o});
    wr(`DPO_A_BUILD_OUT_CTRL, 8'h01);
    tick(3);
    chk("zero_phase_lock", 24'h0, {23'h0, zero_phase_lock_o});
    wr(`DPO_A_BUILD_OUT_CTRL, 8'h00);
    tick(3);
    // A negative offset while locked, then a change held back in free-run.
    set_ofs(17'h1FFF8);
    wait_ofs(17'h1FFF8);
    @(posedge clock_i) main_state_i <= `DPO_ST_FREERUN;
    set_ofs(17'h00028);
    tick(40);
    chk("fb_offset_freerun", 24'h01FFF8, {7'h00, fb_offset_o});
    @(posedge clock_i) main_state_i <= `DPO_ST_LOCKING;
    tick(2);
    chk("fb_offset_ramping", 24'h1, {23'h0, fb_offset_o !== 17'h00028});
    wait_ofs(17'h00028);
    @(posedge clock_i) main_state_i <= `DPO_ST_LOCKED;
    // Recalibration with an offset rewrite in the middle of it.
    wr(`DPO_A_FRAME_SYNC_CTRL3, 8'h01);
    for (n = 0; n < 10 && mini_holdover_o !== 1'b1; n++) tick(1);
    chk("mini_holdover_rise", 24'h1, {23'h0, mini_holdover_o});
    rchk(`DPO_A_FRAME_SYNC_CTRL3, 8'h02, "recalibration_trigger_busy");
    set_ofs(17'h00014);
    for (n = 0; n < 300 && div_reset_o !== 1'b1; n++) tick(1);
    chk("fb_offset_at_divrst", 24'h0, {7'h00, fb_offset_o});
    for (n = 0; n < 50 && div_reset_o === 1'b1; n++) tick(1);
    chk("div_reset_len", 24'd8, n[23:0]);
    for (n = 0; n < 300 && mini_holdover_o === 1'b1; n++) tick(1);
    chk("mini_holdover_fall", 24'h0, {23'h0, mini_holdover_o});
    chk("fb_offset_after_recalibration_trigger", 24'h14, {7'h00, fb_offset_o});
    // Frequency snapshot from each loop; later bytes come from the first read's sample.
    for (int s = 0; s < 2; s++) begin
      wr(`DPO_A_MASTER_CTRL11, s[7:0]);
      tick(2);
      rchk(`DPO_A_READOUT_FIELD_A_A, s ? 8'hEF : 8'h56, "readout_field_a_a");
      main_integral_i <= 24'h777777;
      aux_integral_i <= 24'h777777;
      rchk(`DPO_A_READOUT_FIELD_A_B, s ? 8'hCD : 8'h34, "readout_field_a_b");
      rchk(`DPO_A_READOUT_FIELD_A_C, s ? 8'hAB : 8'h12, "readout_field_a_c");
      main_integral_i <= 24'h123456;
      aux_integral_i <= 24'hABCDEF;
      // The filtered phase settles on the selected detector error; the high byte comes from the snapshot.
      tick(200);
      rchk(`DPO_A_PHASE_A, 8'h00, "phase_a");
      rchk(`DPO_A_PHASE_B, s ? 8'hFF : 8'h01, "phase_b");
    end
    // Measurement mode, forced selection of every input and the copy mode table.
    wr(`DPO_A_MAIN_PLL_CTRL1, 8'h01);
    tick(3);
    chk("aux_freerun", 24'h1, {23'h0, aux_freerun_o});
    chk("aux_cmp_main", 24'h1, {23'h0, aux_cmp_main_o});
    for (int s = 0; s < 8; s++) begin
      wr(`DPO_A_MASTER_CTRL4, s[7:0]);
      tick(3);
      chk("aux_ref_sel", s[23:0], {21'h0, aux_ref_sel_o});
    end
    for (int a = 0; a < 3; a++) begin
      for (int m = 0; m < 4; m++) begin
        wr(`DPO_A_INPUT_CFG, {4'h0, a[1:0], m[1:0]});
        tick(3);
        n = (a == 0 || m == 3) ? 0 : (m == 2 ? 2 : 1);
        chk("copy_mode", n[23:0], {22'h0, copy_mode_o});
        // The copy toggles every two cycles when direct and half as often when divided by the reset divisor.
        t = 0;
        for (int k = 0; k < 40; k++) begin
          p = copy_ref_o;
          tick(1);
          t += (copy_ref_o !== p);
        end
        chk("copy_ref_toggles", (n != 0) ? 24'd10 : 24'd20, t[23:0]);
      end
    end
    wr(`DPO_A_MAIN_PLL_CTRL1, 8'h00);
    aux_auto_sel_i <= 3'h6;
    tick(3);
    chk("aux_ref_sel_auto", 24'h6, {21'h0, aux_ref_sel_o});
    chk("aux_freerun_off", 24'h0, {23'h0, aux_freerun_o});
    // Bandwidth codes, with the main code clamped to the last of its 21 corners.
    wr(`DPO_A_BANDWIDTH, 8'h75);
    tick(3);
    chk("main_bw_clamp", 24'h14, {19'h0, main_bw_o});
    chk("aux_bw", 24'h3, {22'h0, aux_bw_o});
    wr(`DPO_A_BANDWIDTH, 8'h2A);
    tick(3);
    chk("main_bw", 24'h0A, {19'h0, main_bw_o});
    chk("aux_bw", 24'h1, {22'h0, aux_bw_o});
    // Input validity against the frequency limit, then against a tightened slew limit.
    @(posedge clock_i) in_meas_stb_i <= 1'b1;
    @(posedge clock_i) in_meas_stb_i <= 1'b0;
    tick(2);
    chk("in_valid", 24'hFD, {16'h0, in_valid_o});
    wr(`DPO_A_SLEW_LIMIT, 8'h05);
    in_readout_field_a_i <= 64'h0000_0000_00EB_1E14;
    @(posedge clock_i) in_meas_stb_i <= 1'b1;
    @(posedge clock_i) in_meas_stb_i <= 1'b0;
    tick(2);
    chk("in_valid_slew", 24'hFC, {16'h0, in_valid_o});
    complete_run();
  end
endmodule : tb_top
